// file: inc/ipf_pkg.sv
// shared constants and types for the instruction parcel fetch and decode block
package ipf_pkg;
  localparam int unsigned PARCEL_W             = 16;
  localparam int unsigned ADDR_W               = 32;
  localparam int unsigned MAX_INSTR_LENGTH     = 32;
  localparam int unsigned INSTR_ADDR_ALIGNMENT = 16;
  localparam logic [1:0]  LEN_FULL_CODE        = 2'h3;
  localparam logic [ADDR_W-1:0] RESET_PC       = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PARCEL_STEP    = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] TRAP_VECTOR    = 32'h0000_0100;
  localparam logic [ADDR_W-1:0] ECALL_VECTOR   = 32'h0000_0200;
  localparam logic [31:0] ECALL_WORD           = 32'h0000_0073;
  // trap classes seen by the surrounding environment
  typedef enum logic [3:0]
  {
    IPF_TRAP_CONTAINED = 4'h1,
    IPF_TRAP_REQUESTED = 4'h2,
    IPF_TRAP_INVISIBLE = 4'h4,
    IPF_TRAP_FATAL     = 4'h8
  } ipf_trap_t;
  typedef enum logic [4:0]
  {
    IPF_EXC_NONE    = 5'h00,
    IPF_EXC_ILLEGAL = 5'h02,
    IPF_EXC_ECALL_U = 5'h08
  } ipf_exc_t;
endpackage

// file: verilog/ipf_len_decode.sv
// length and illegal-pattern classifier for the first and second parcels
`timescale 1ns/1ps
module ipf_len_decode
  import ipf_pkg::*;
(
  input  wire logic [ipf_pkg::PARCEL_W-1:0] i_parcel_lo,
  input  wire logic [ipf_pkg::PARCEL_W-1:0] i_parcel_hi,
  input  wire logic                         i_compressed_en,
  output logic                              o_is_full,
  output logic                              o_illegal
);
  import ipf_pkg::*;
  always_comb
  begin
    // length from the low bits of the first parcel only
    o_is_full = (i_parcel_lo[1:0] == LEN_FULL_CODE) || !i_compressed_en;
    o_illegal = 1'b0;
    if (i_parcel_lo == 16'h0000)
    begin
      o_illegal = 1'b1;
      o_is_full = !i_compressed_en;
    end
    else if (o_is_full && (i_parcel_lo == 16'hffff) && (i_parcel_hi == 16'hffff))
    begin
      o_illegal = 1'b1;
    end
    else if (!o_is_full && i_parcel_lo == 16'hffff)
    begin
      o_illegal = 1'b0;
    end
  end
endmodule

// file: verilog/ipf_fetch_decode.sv
// instruction parcel fetch, assembly and exception signalling
`timescale 1ns/1ps
module ipf_fetch_decode
  import ipf_pkg::*;
(
  input  wire logic                         i_core_clk,
  input  wire logic                         i_resetn,
  input  wire logic                         i_compressed_en,
  input  wire logic                         i_user_mode,
  input  wire logic                         i_fp_exception,
  input  wire logic                         i_unassigned,
  input  wire logic                         i_redirect,
  input  wire logic [ipf_pkg::ADDR_W-1:0]   i_redirect_pc,
  input  wire logic                         i_mem_ready,
  input  wire logic                         i_mem_valid,
  input  wire logic [7:0]                   i_mem_byte0,
  input  wire logic [7:0]                   i_mem_byte1,
  input  wire logic                         i_instr_ready,
  output logic                              o_mem_req,
  output logic [ipf_pkg::ADDR_W-1:0]        o_mem_addr,
  output logic                              o_instr_valid,
  output logic [31:0]                       o_instr,
  output logic [ipf_pkg::ADDR_W-1:0]        o_instr_pc,
  output logic                              o_instr_is_full,
  output logic                              o_exc_valid,
  output ipf_pkg::ipf_exc_t                 o_exc_cause,
  output logic [ipf_pkg::ADDR_W-1:0]        o_exc_pc,
  output ipf_pkg::ipf_trap_t                o_trap_class,
  output logic                              o_trap_take,
  output logic [ipf_pkg::ADDR_W-1:0]        o_trap_target,
  output logic                              o_supervisor_mode,
  output logic                              o_halted
);
  import ipf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_REQ_LO  = 5'h01,
    ST_WAIT_LO = 5'h02,
    ST_REQ_HI  = 5'h04,
    ST_WAIT_HI = 5'h08,
    ST_ISSUE   = 5'h10
  } ipf_state_t;

  function automatic logic [PARCEL_W-1:0] parcel_of(input logic [7:0] b0, input logic [7:0] b1);
    // lower byte address is the low byte, whatever data endianness says
    parcel_of = {b1, b0};
  endfunction

  ipf_state_t          state_reg, state_next;
  logic [ADDR_W-1:0]   pc_reg, pc_next;
  logic [ADDR_W-1:0]   fetch_reg, fetch_next;
  logic [15:0]         lo_reg, lo_next;
  logic [15:0]         hi_reg, hi_next;
  logic                full_reg, full_next;
  logic                valid_reg, valid_next;
  logic [31:0]         instr_reg, instr_next;
  logic [ADDR_W-1:0]   ipc_reg, ipc_next;
  logic                ifull_reg, ifull_next;
  logic                exc_reg, exc_next;
  ipf_exc_t            cause_reg, cause_next;
  logic [ADDR_W-1:0]   epc_reg, epc_next;
  ipf_trap_t           tclass_reg, tclass_next;
  logic                take_reg, take_next;
  logic [ADDR_W-1:0]   ttgt_reg, ttgt_next;
  logic                smode_reg, smode_next;
  logic                halt_reg, halt_next;
  logic [15:0]         parcel_in;
  logic                dec_full;
  logic                dec_illegal;
  logic [31:0]         assembled;

  assign parcel_in = parcel_of(i_mem_byte0, i_mem_byte1);
  assign assembled = full_reg ? {hi_reg, lo_reg} : {16'h0000, lo_reg};

  ipf_len_decode u_len
  (
    .i_parcel_lo     (lo_reg),
    .i_parcel_hi     (hi_reg),
    .i_compressed_en (i_compressed_en),
    .o_is_full       (dec_full),
    .o_illegal       (dec_illegal)
  );

  // ----------------------------------------------------------------
  // fetch sequencing and decode
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    pc_next     = pc_reg;
    fetch_next  = fetch_reg;
    lo_next     = lo_reg;
    hi_next     = hi_reg;
    full_next   = full_reg;
    valid_next  = valid_reg && !i_instr_ready;
    instr_next  = instr_reg;
    ipc_next    = ipc_reg;
    ifull_next  = ifull_reg;
    exc_next    = 1'b0;
    cause_next  = cause_reg;
    epc_next    = epc_reg;
    tclass_next = tclass_reg;
    take_next   = 1'b0;
    ttgt_next   = ttgt_reg;
    smode_next  = smode_reg;
    halt_next   = halt_reg;
    case (state_reg)
      ST_REQ_LO:
      begin
        if (i_mem_ready && !halt_reg)
        begin
          state_next = ST_WAIT_LO;
        end
      end
      ST_WAIT_LO:
      begin
        if (i_mem_valid)
        begin
          lo_next = parcel_in;
          // decide length before any later parcel is looked at
          full_next = (parcel_in[1:0] == LEN_FULL_CODE) || !i_compressed_en;
          if (parcel_in == 16'h0000)
          begin
            full_next = !i_compressed_en;
          end
          hi_next = 16'h0000;
          fetch_next = fetch_reg + PARCEL_STEP;
          state_next = full_next ? ST_REQ_HI : ST_ISSUE;
        end
      end
      ST_REQ_HI:
      begin
        if (i_mem_ready)
        begin
          state_next = ST_WAIT_HI;
        end
      end
      ST_WAIT_HI:
      begin
        if (i_mem_valid)
        begin
          hi_next = parcel_in;
          fetch_next = fetch_reg + PARCEL_STEP;
          state_next = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        if (!valid_reg || i_instr_ready)
        begin
          epc_next = pc_reg;
          if (dec_illegal || i_unassigned)
          begin
            exc_next    = 1'b1;
            cause_next  = IPF_EXC_ILLEGAL;
            take_next   = 1'b1;
            ttgt_next   = TRAP_VECTOR;
            // unassigned encodings stop the hart instead of executing
            tclass_next = i_unassigned ? IPF_TRAP_FATAL : IPF_TRAP_CONTAINED;
            halt_next   = i_unassigned;
          end
          else if (full_reg && assembled == ECALL_WORD && i_user_mode)
          begin
            exc_next    = 1'b1;
            cause_next  = IPF_EXC_ECALL_U;
            take_next   = 1'b1;
            ttgt_next   = ECALL_VECTOR;
            smode_next  = 1'b1;
            tclass_next = IPF_TRAP_CONTAINED;
          end
          else
          begin
            valid_next = 1'b1;
            instr_next = assembled;
            ipc_next   = pc_reg;
            ifull_next = full_reg;
          end
          // the faulting instruction is never issued, so the trap is precise
          pc_next    = take_next ? ttgt_next : fetch_reg;
          fetch_next = pc_next;
          state_next = ST_REQ_LO;
        end
      end
      default:
      begin
        state_next = ST_REQ_LO;
      end
    endcase
    // floating-point flags never redirect the hart
    if (i_fp_exception)
    begin
      take_next = take_next;
    end
    if (i_redirect && !halt_next)
    begin
      // unless the hart halts this cycle, a redirect squashes whatever this cycle would issue,
      // so no contained trap or instruction from the abandoned path reaches the consumer
      valid_next  = 1'b0;
      exc_next    = 1'b0;
      take_next   = 1'b0;
      cause_next  = cause_reg;
      epc_next    = epc_reg;
      tclass_next = tclass_reg;
      ttgt_next   = ttgt_reg;
      pc_next    = i_redirect_pc;
      fetch_next = i_redirect_pc;
      state_next = ST_REQ_LO;
      smode_next = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg  <= ST_REQ_LO;
      pc_reg     <= RESET_PC;
      fetch_reg  <= RESET_PC;
      lo_reg     <= 16'h0000;
      hi_reg     <= 16'h0000;
      full_reg   <= 1'b0;
      valid_reg  <= 1'b0;
      instr_reg  <= 32'h0000_0000;
      ipc_reg    <= RESET_PC;
      ifull_reg  <= 1'b0;
      exc_reg    <= 1'b0;
      cause_reg  <= IPF_EXC_NONE;
      epc_reg    <= RESET_PC;
      tclass_reg <= IPF_TRAP_CONTAINED;
      take_reg   <= 1'b0;
      ttgt_reg   <= TRAP_VECTOR;
      smode_reg  <= 1'b0;
      halt_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      fetch_reg  <= fetch_next;
      lo_reg     <= lo_next;
      hi_reg     <= hi_next;
      full_reg   <= full_next;
      valid_reg  <= valid_next;
      instr_reg  <= instr_next;
      ipc_reg    <= ipc_next;
      ifull_reg  <= ifull_next;
      exc_reg    <= exc_next;
      cause_reg  <= cause_next;
      epc_reg    <= epc_next;
      tclass_reg <= tclass_next;
      take_reg   <= take_next;
      ttgt_reg   <= ttgt_next;
      smode_reg  <= smode_next;
      halt_reg   <= halt_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_mem_req         = (state_reg == ST_REQ_LO && !halt_reg) || state_reg == ST_REQ_HI;
  assign o_mem_addr        = fetch_reg;
  assign o_instr_valid     = valid_reg;
  assign o_instr           = instr_reg;
  assign o_instr_pc        = ipc_reg;
  assign o_instr_is_full   = ifull_reg;
  assign o_exc_valid       = exc_reg;
  assign o_exc_cause       = cause_reg;
  assign o_exc_pc          = epc_reg;
  assign o_trap_class      = tclass_reg;
  assign o_trap_take       = take_reg;
  assign o_trap_target     = ttgt_reg;
  assign o_supervisor_mode = smode_reg;
  assign o_halted          = halt_reg;
endmodule

// file: sim/ipf_fetch_decode_assertions.sv
// bound checker for the parcel fetch and decode block
`timescale 1ns/1ps
module ipf_fetch_decode_chk
  import ipf_pkg::*;
(
  input wire logic                  i_core_clk,
  input wire logic                  i_resetn,
  input wire logic                  i_redirect,
  input wire logic                  i_instr_ready,
  input wire logic                  o_mem_req,
  input wire logic [ipf_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic                  o_instr_valid,
  input wire logic [31:0]           o_instr,
  input wire logic                  o_instr_is_full,
  input wire logic                  o_exc_valid,
  input wire ipf_pkg::ipf_exc_t     o_exc_cause,
  input wire ipf_pkg::ipf_trap_t    o_trap_class,
  input wire logic                  o_trap_take,
  input wire logic [ipf_pkg::ADDR_W-1:0] o_trap_target,
  input wire logic                  o_supervisor_mode,
  input wire logic                  o_halted
);
  import ipf_pkg::*;
  // ------
  // properties
  // ------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ecall;
    o_exc_valid && o_exc_cause == IPF_EXC_ECALL_U;
  endsequence
  sequence s_fatal;
    o_trap_take && o_trap_class == IPF_TRAP_FATAL;
  endsequence
  chk_exc_pulse: assert property (o_exc_valid |=> !o_exc_valid)
    else $error("exception pulse longer than one cycle");
  chk_trap_pair: assert property (o_exc_valid == o_trap_take)
    else $error("trap and exception not paired");
  chk_halt_sticky: assert property (o_halted |=> o_halted)
    else $error("halt released without reset");
  chk_halt_quiet: assert property (o_halted |-> !o_mem_req)
    else $error("fetch while halted");
  chk_fatal_halt: assert property (s_fatal |-> ##[0:1] o_halted)
    else $error("fatal trap did not halt");
  chk_ecall_super: assert property (s_ecall |-> (o_trap_target == ECALL_VECTOR) ##[0:1] o_supervisor_mode)
    else $error("user call not routed to supervisor");
  chk_trap_refetch: assert property (o_trap_take && o_trap_class != IPF_TRAP_FATAL
    |-> ##[0:2] (o_mem_req && o_mem_addr == o_trap_target))
    else $error("no fetch from trap target");
  chk_instr_hold: assert property (o_instr_valid && !i_instr_ready && !i_redirect
    |=> o_instr_valid && $stable(o_instr))
    else $error("instruction dropped before taken");
  chk_no_illegal: assert property (o_instr_valid |-> o_instr[15:0] != 16'h0 && o_instr != 32'hffff_ffff)
    else $error("illegal pattern issued");
  chk_full_code: assert property (o_instr_valid && o_instr[1:0] == LEN_FULL_CODE |-> o_instr_is_full)
    else $error("low bits 11 not full length");
  chk_short_upper: assert property (o_instr_valid && !o_instr_is_full |-> o_instr[31:16] == 16'h0)
    else $error("short instruction has upper bits");
  chk_addr_even: assert property (o_mem_req |-> o_mem_addr[0] == 1'h0)
    else $error("fetch address not halfword aligned");
endmodule
bind ipf_fetch_decode ipf_fetch_decode_chk u_chk (.i_core_clk, .i_resetn, .i_redirect, .i_instr_ready,
  .o_mem_req, .o_mem_addr, .o_instr_valid, .o_instr, .o_instr_is_full, .o_exc_valid, .o_exc_cause,
  .o_trap_class, .o_trap_take, .o_trap_target, .o_supervisor_mode, .o_halted);

// file: sim/ipf_imem_model.sv
// instruction memory answering halfword parcel fetches with random delays
`timescale 1ns/1ps
module ipf_imem_model
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  output logic             o_ready,
  output logic             o_valid,
  output logic [7:0]       o_byte0,
  output logic [7:0]       o_byte1
);
  logic [15:0] mem [0:1023];
  logic        busy;
  logic [9:0]  idx;
  int          seed = 4711;
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ready <= 1'h0;
      o_valid <= 1'h0;
      busy <= 1'h0;
      o_byte0 <= 8'h5a;
      o_byte1 <= 8'ha5;
    end
    else
    begin
      o_valid <= 1'h0;
      // idle bytes toggle so a stale parcel never looks fresh
      o_byte0 <= ~o_byte0;
      o_byte1 <= ~o_byte1;
      o_ready <= !busy && $random(seed) % 3 != 0;
      if (i_req && o_ready)
      begin
        busy <= 1'h1;
        idx <= i_addr[10:1];
        o_ready <= 1'h0;
      end
      else if (busy && $random(seed) % 2 == 0)
      begin
        busy <= 1'h0;
        o_valid <= 1'h1;
        {o_byte1, o_byte0} <= mem[idx];
      end
    end
  end
endmodule

// file: sim/tb.sv
// self-checking bench for the parcel fetch and decode block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  import ipf_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, cen = 1'h1, user = 1'h1, fp = 1'h0, unas = 1'h0, redir = 1'h0;
  logic        iready = 1'h0, mute = 1'h1, mreq, mrdy, mval, ivalid, ifull, evalid, ttake, smode, halted, f, ec;
  logic [7:0]  b0, b1;
  logic [15:0] h;
  logic [31:0] rpc = 32'h0, maddr, instr, ipc, xpc, ttgt, epc, w;
  ipf_exc_t    cause;
  ipf_trap_t   tclass;
  int          bad_count = 0, tests_run = 0, seed = 22253, nexc = 0;
  ipf_fetch_decode dut (.i_core_clk(clk), .i_resetn(rstn), .i_compressed_en(cen), .i_user_mode(user),
    .i_fp_exception(fp), .i_unassigned(unas), .i_redirect(redir), .i_redirect_pc(rpc), .i_mem_ready(mrdy),
    .i_mem_valid(mval), .i_mem_byte0(b0), .i_mem_byte1(b1), .i_instr_ready(iready), .o_mem_req(mreq),
    .o_mem_addr(maddr), .o_instr_valid(ivalid), .o_instr(instr), .o_instr_pc(ipc), .o_instr_is_full(ifull),
    .o_exc_valid(evalid), .o_exc_cause(cause), .o_exc_pc(xpc), .o_trap_class(tclass), .o_trap_take(ttake),
    .o_trap_target(ttgt), .o_supervisor_mode(smode), .o_halted(halted));
  ipf_imem_model u_mem (.i_clk(clk), .i_resetn(rstn), .i_req(mreq), .i_addr(maddr), .o_ready(mrdy),
    .o_valid(mval), .o_byte0(b0), .o_byte1(b1));
  // ------
  // reference and monitor
  // ------
  function automatic logic [31:0] exp_word(input logic [31:0] pc, output logic full);
    logic [15:0] lo;
    lo = u_mem.mem[pc[10:1]];
    full = !cen || lo[1:0] == LEN_FULL_CODE;
    return full ? {u_mem.mem[pc[10:1] + 10'h1], lo} : {16'h0, lo};
  endfunction
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    iready <= $random(seed) % 4 != 0;
    fp <= $random(seed) % 8 == 0;
  end
  always @(posedge clk)
  begin
    if (rstn && !mute && ivalid && iready)
    begin
      w = exp_word(epc, f);
      `CHK(ipc, epc)
      `CHK(instr, w)
      `CHK(ifull, f)
      `CHK(w[15:0] == 16'h0 || w == 32'hffff_ffff, 1'h0)
      epc = epc + (f ? 32'h4 : 32'h2);
    end
    if (rstn && !mute && evalid)
    begin
      w = exp_word(epc, f);
      ec = f && w == ECALL_WORD && user;
      `CHK(xpc, epc)
      `CHK(w[15:0] == 16'h0 || w == 32'hffff_ffff || ec, 1'h1)
      `CHK(cause, ec ? IPF_EXC_ECALL_U : IPF_EXC_ILLEGAL)
      `CHK(tclass, IPF_TRAP_CONTAINED)
      epc = ec ? ECALL_VECTOR : TRAP_VECTOR;
      `CHK(ttgt, epc)
      nexc++;
    end
    if (redir)
      epc = rpc;
  end
  // ------
  // tasks and sequence
  // ------
  task automatic jump(input logic [31:0] pc, input logic c);
    @(posedge clk);
    redir <= 1'h1;
    rpc <= pc;
    @(posedge clk);
    redir <= 1'h0;
    cen <= c;
  endtask
  task automatic hit(input logic [31:0] pc, input logic c);
    int n;
    n = nexc;
    jump(pc, c);
    repeat (100) if (nexc == n) @(posedge clk);
    `CHK(nexc != n, 1'h1)
    repeat (20) @(posedge clk);
    $display("trap test at %h done", pc);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    // trap vector page and top page hold only full-length parcels, apart from the zero pair at 10'h320, safe in either length mode
    for (int i = 0; i < 1024; i++)
    begin
      h = 16'($random(seed)) | ((i >= 768 || (i >> 7) == 1) ? 16'h3 : 16'h0);
      if (h == 16'h0 || h == 16'hffff)
        h = 16'h0013;
      u_mem.mem[i] = h;
    end
    u_mem.mem[10'h20] = 16'h0;
    u_mem.mem[10'h24] = 16'hffff;
    u_mem.mem[10'h25] = 16'hffff;
    u_mem.mem[10'h28] = ECALL_WORD[15:0];
    u_mem.mem[10'h29] = ECALL_WORD[31:16];
    u_mem.mem[10'h320] = 16'h0;
    u_mem.mem[10'h321] = 16'h0;
    repeat (16) @(posedge clk);
    `CHK(mreq, 1'h1)
    `CHK(tclass, IPF_TRAP_CONTAINED)
    `CHK(ttgt, TRAP_VECTOR)
    `CHK(ivalid | evalid | halted, 1'h0)
    rstn <= 1'h1;
    epc = RESET_PC;
    mute = 1'h0;
    repeat (400) @(posedge clk);
    $display("free run done");
    hit(32'h40, 1'h1);
    hit(32'h48, 1'h1);
    hit(32'h640, 1'h0);
    hit(32'h50, 1'h1);
    `CHK(smode, 1'h1)
    // outside user mode the call word is an ordinary instruction
    user <= 1'h0;
    jump(32'h50, 1'h1);
    repeat (40) @(posedge clk);
    `CHK(smode, 1'h0)
    user <= 1'h1;
    $display("supervisor call test done");
    jump(32'h600, 1'h0);
    repeat (200) @(posedge clk);
    `CHK(smode, 1'h0)
    $display("full length run done");
    mute = 1'h1;
    unas <= 1'h1;
    repeat (100) if (!evalid) @(posedge clk);
    `CHK(tclass, IPF_TRAP_FATAL)
    repeat (3) @(posedge clk);
    jump(32'h0, 1'h1);
    repeat (20) @(posedge clk);
    `CHK({halted, mreq}, 2'h2)
    $display("fatal trap test done");
    rstn <= 1'h0;
    unas <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK(halted, 1'h0)
    rstn <= 1'h1;
    epc = RESET_PC;
    mute = 1'h0;
    repeat (200) @(posedge clk);
    $display("second reset run done");
    results();
  end
  // the whole sequence needs under 1500 cycles; the 20000-cycle limit means a hang
  initial
  begin
    #(8 * 20000);
    bad_count++;
    results();
  end
endmodule
